// ### rtl/camc_pkg.sv
// Package with register map, field layouts, encodings and counts of the counter array configuration block.
package camc_pkg;

   localparam int          NUM_CH        = 6;
   localparam int          IDX_W         = 10;
   localparam int          CNT_W         = 16;

   // Register indices; the byte address on the bus is four times the index.
   localparam logic [9:0]  MODE_IDX      = 10'h0d9;
   localparam logic [9:0]  PWM_IDX       = 10'h0df;
   localparam logic [9:0]  STATUS_IDX    = 10'h0e0;
   localparam logic [9:0]  COUNT_IDX     = 10'h0e2;
   localparam logic [9:0]  WIN_BASE_IDX  = 10'h0e8;
   localparam logic [9:0]  WIN_SPAN      = 10'h00c;

   // Field positions in the status register and in the channel window read.
   localparam int          STATUS_OVF_BIT = 7;
   localparam int          HIGH_BYTE_LSB  = 8;

   // Reset values and counter maximum.
   localparam logic [7:0]  MODE_RESET    = 8'h40;
   localparam logic [7:0]  PWM_RESET     = 8'h00;
   localparam logic [15:0] CNT_RESET     = 16'h0000;
   localparam logic [15:0] CNT_MAX       = 16'hffff;

   // Timebase division counts.
   localparam int          SYS_DIV_SLOW  = 12;
   localparam int          SYS_DIV_FAST  = 4;
   localparam int          PIN_CLK_DIV   = 8;
   localparam int          ECI_MAX_DIV   = 4;
   localparam int          PRE_W         = 4;
   localparam logic [3:0]  PRE_LAST      = 4'(SYS_DIV_SLOW - 1);
   localparam logic [1:0]  FAST_LAST     = 2'(SYS_DIV_FAST - 1);
   localparam logic [2:0]  PIN_DIV_LAST  = 3'(PIN_CLK_DIV - 1);

   // Period widths handed to the PWM channels.
   localparam logic [4:0]  PERIOD_BASE   = 5'h08;
   localparam logic [4:0]  PERIOD_WIDE   = 5'h10;

   typedef enum logic [2:0]
   {
      TB_SYS_DIV12 = 3'h0,
      TB_SYS_DIV4  = 3'h1,
      TB_TIMER0    = 3'h2,
      TB_EXT_FALL  = 3'h3,
      TB_SYS       = 3'h4,
      TB_EXT_DIV8  = 3'h5,
      TB_RTC_DIV8  = 3'h6,
      TB_RESERVED  = 3'h7
   } camc_timebase_e;

   typedef enum logic [1:0]
   {
      CL_8  = 2'h0,
      CL_9  = 2'h1,
      CL_10 = 2'h2,
      CL_11 = 2'h3
   } camc_cycle_len_e;

   typedef struct packed
   {
      logic           idle_suspend;
      logic           wdog_enable;
      logic           wdog_enable_lock;
      logic           unused;
      camc_timebase_e timebase_select;
      logic           counter_ovf_irq_enable;
   } camc_mode_s;

   typedef struct packed
   {
      logic            reload_window_select;
      logic            cycle_ovf_irq_enable;
      logic            cycle_ovf_flag;
      logic [2:0]      unused;
      camc_cycle_len_e cycle_length_select;
   } camc_pwm_s;

   typedef struct packed
   {
      logic [4:0]  period_bits;
      logic        reload_active;
      logic [15:0] reload;
      logic [15:0] compare;
   } camc_chan_cfg_s;

endpackage

// ### rtl/camc_sync.sv
// Three-stage input synchroniser that accepts a change once the last two stages agree.
`timescale 1ns/10ps
module camc_sync #(
   parameter int W = 1
) (
   input  wire logic         sys_clk_in,
   input  wire logic         arst_n_in,
   input  wire logic         ce_in,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] level_out
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // The first stage feeds only the second; the filter looks at stages two and three.
   always_ff @(posedge sys_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         s1_q      <= '0;
         s2_q      <= '0;
         s3_q      <= '0;
         level_out <= '0;
      end
      else if (ce_in)
      begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (int i = 0; i < W; i++)
         begin
            if (s2_q[i] == s3_q[i])
               level_out[i] <= s3_q[i];
         end
      end
   end
endmodule // camc_sync

// ### rtl/camc_timebase.sv
// Counter increment source selection with prescaler and pin clock dividers.
`timescale 1ns/10ps
module camc_timebase (
   input  wire logic                     sys_clk_in,
   input  wire logic                     arst_n_in,
   input  wire logic                     ce_in,
   input  wire camc_pkg::camc_timebase_e sel_in,
   input  wire logic                     timer0_ovf_in,
   input  wire logic                     eci_level_in,
   input  wire logic                     ext_level_in,
   input  wire logic                     rtc_level_in,
   output logic                          tick_out
);
   import camc_pkg::*;

   logic [PRE_W-1:0] pre_q;
   logic             eci_q;
   logic             ext_q;
   logic             rtc_q;
   logic [2:0]       ext_div_q;
   logic [2:0]       rtc_div_q;
   logic             tick_d;

   always_ff @(posedge sys_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         pre_q     <= '0;
         eci_q     <= 1'b0;
         ext_q     <= 1'b0;
         rtc_q     <= 1'b0;
         ext_div_q <= '0;
         rtc_div_q <= '0;
         tick_out  <= 1'b0;
      end
      else if (ce_in)
      begin
         pre_q <= (pre_q == PRE_LAST) ? '0 : pre_q + 1'b1;
         eci_q <= eci_level_in;
         ext_q <= ext_level_in;
         rtc_q <= rtc_level_in;
         if (ext_level_in && !ext_q)
            ext_div_q <= ext_div_q + 1'b1;
         if (rtc_level_in && !rtc_q)
            rtc_div_q <= rtc_div_q + 1'b1;
         tick_out <= tick_d;
      end
   end

   // Pin clocks are counted only after resynchronisation, so every pin-clock tick is one system clock wide.
   always_comb
   begin
      tick_d = 1'b0;
      unique case (sel_in)
         TB_SYS_DIV12: tick_d = (pre_q == PRE_LAST);
         TB_SYS_DIV4:  tick_d = (pre_q[1:0] == FAST_LAST);
         TB_TIMER0:    tick_d = timer0_ovf_in;
         TB_EXT_FALL:  tick_d = eci_q && !eci_level_in;
         TB_SYS:       tick_d = 1'b1;
         TB_EXT_DIV8:  tick_d = ext_level_in && !ext_q && (ext_div_q == PIN_DIV_LAST);
         TB_RTC_DIV8:  tick_d = rtc_level_in && !rtc_q && (rtc_div_q == PIN_DIV_LAST);
         TB_RESERVED:  tick_d = 1'b0;
      endcase
   end
endmodule // camc_timebase

// ### rtl/camc_top.sv
// Mode and PWM configuration registers, main counter and overflow flags of the counter array.
`timescale 1ns/10ps

module camc_top (
   input  wire logic                                            sys_clk_in,
   input  wire logic                                            arst_n_in,
   input  wire logic                                            ce_in,
   input  wire logic                                            wb_cyc_in,
   input  wire logic                                            wb_stb_in,
   input  wire logic                                            wb_we_in,
   input  wire logic [11:0]                                     wb_adr_in,
   input  wire logic [3:0]                                      wb_sel_in,
   input  wire logic [31:0]                                     wb_dat_in,
   output logic      [31:0]                                     wb_dat_out,
   output logic                                                 wb_ack_out,
   input  wire logic                                            cpu_idle_in,
   input  wire logic                                            counter_run_in,
   input  wire logic                                            timer0_ovf_in,
   input  wire logic                                            ext_count_input_in,
   input  wire logic                                            ext_clk_in,
   input  wire logic                                            rtc_clk_in,
   input  wire logic [camc_pkg::NUM_CH-1:0]                     chan_pwm_en_in,
   input  wire logic [camc_pkg::NUM_CH-1:0]                     chan_pwm16_in,
   output camc_pkg::camc_chan_cfg_s [camc_pkg::NUM_CH-1:0]      chan_cfg_out,
   output logic      [15:0]                                     main_counter_out,
   output logic                                                 wdog_active_out,
   output logic                                                 irq_out
);
   import camc_pkg::*;

   camc_mode_s       mode_q;
   camc_pwm_s        pwm_q;
   logic             cnt_ovf_flag_q;
   logic [CNT_W-1:0] cnt_q;
   logic [15:0]      cmp_q [NUM_CH];
   logic [15:0]      rld_q [NUM_CH];
   logic             ack_q;
   logic [31:0]      dat_q;

   logic             req;
   logic [IDX_W-1:0] idx;
   logic             mapped;
   logic             wr_lane0;
   logic             wr_lane1;
   logic [IDX_W-1:0] win_off;
   logic             win_hit;
   logic [2:0]       win_ch;
   logic             win_high;
   camc_mode_s       mode_wr;
   camc_pwm_s        pwm_wr;
   logic [2:0]       pin_level;
   logic             tick;
   logic             run;
   logic             step;
   logic [CNT_W-1:0] cyc_mask;
   logic             cnt_wrap;
   logic             cyc_wrap;
   logic [31:0]      rd_d;
   logic [15:0]      win_word;

   // Request decode; address bits one and zero are ignored, so each register answers at four byte addresses.
   assign req      = wb_cyc_in && wb_stb_in && !ack_q;
   assign idx      = wb_adr_in[11:2];
   assign wr_lane0 = req && wb_we_in && wb_sel_in[0];
   assign wr_lane1 = req && wb_we_in && wb_sel_in[1];
   assign mode_wr  = wb_dat_in[7:0];
   assign pwm_wr   = wb_dat_in[7:0];
   assign win_off  = idx - WIN_BASE_IDX;
   assign win_hit  = (idx >= WIN_BASE_IDX) && (win_off < WIN_SPAN);
   assign win_ch   = win_off[3:1];
   assign win_high = win_off[0];

   // External pins are resynchronised before any edge logic sees them.
   camc_sync #(
      .W (3)
   ) u_sync (
      .sys_clk_in (sys_clk_in),
      .arst_n_in  (arst_n_in),
      .ce_in      (ce_in),
      .async_in   ({rtc_clk_in, ext_clk_in, ext_count_input_in}),
      .level_out  (pin_level)
   );

   camc_timebase u_timebase (
      .sys_clk_in    (sys_clk_in),
      .arst_n_in     (arst_n_in),
      .ce_in         (ce_in),
      .sel_in        (mode_q.timebase_select),
      .timer0_ovf_in (timer0_ovf_in),
      .eci_level_in  (pin_level[0]),
      .ext_level_in  (pin_level[1]),
      .rtc_level_in  (pin_level[2]),
      .tick_out      (tick)
   );

   // The watchdog forces the counter on; idle suspend still halts it so the watchdog sleeps with the CPU.
   assign run  = (counter_run_in || mode_q.wdog_enable)
                 && !(mode_q.idle_suspend && cpu_idle_in);
   assign step = run && tick;

   always_comb
   begin
      unique case (pwm_q.cycle_length_select)
         CL_8:  cyc_mask = 16'h00ff;
         CL_9:  cyc_mask = 16'h01ff;
         CL_10: cyc_mask = 16'h03ff;
         CL_11: cyc_mask = 16'h07ff;
      endcase
   end

   // Both wraps are judged on the step itself, so a flag rises at the edge that moves the counter.
   assign cnt_wrap = step && (cnt_q == CNT_MAX);
   assign cyc_wrap = step && ((cnt_q & cyc_mask) == cyc_mask);

   // Main counter.
   always_ff @(posedge sys_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         cnt_q <= CNT_RESET;
      else if (ce_in && step)
         cnt_q <= cnt_q + 1'b1;
   end

   // Mode register: while the watchdog runs only its enable may change, and only when unlocked.
   always_ff @(posedge sys_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         mode_q <= MODE_RESET;
      else if (ce_in && wr_lane0 && idx == MODE_IDX)
      begin
         if (mode_q.wdog_enable)
         begin
            if (!mode_q.wdog_enable_lock)
               mode_q.wdog_enable <= mode_wr.wdog_enable;
         end
         else
         begin
            mode_q.idle_suspend           <= mode_wr.idle_suspend;
            mode_q.wdog_enable_lock       <= mode_wr.wdog_enable_lock;
            mode_q.wdog_enable            <= mode_wr.wdog_enable || mode_wr.wdog_enable_lock;
            mode_q.unused                 <= 1'b0;
            mode_q.timebase_select        <= mode_wr.timebase_select;
            mode_q.counter_ovf_irq_enable <= mode_wr.counter_ovf_irq_enable;
         end
      end
   end

   // PWM configuration register; a hardware set wins over a clear in the same cycle.
   always_ff @(posedge sys_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         pwm_q <= PWM_RESET;
      else if (ce_in)
      begin
         if (wr_lane0 && idx == PWM_IDX)
         begin
            pwm_q.reload_window_select <= pwm_wr.reload_window_select;
            pwm_q.cycle_ovf_irq_enable <= pwm_wr.cycle_ovf_irq_enable;
            pwm_q.cycle_ovf_flag       <= pwm_wr.cycle_ovf_flag || cyc_wrap;
            pwm_q.unused               <= 3'h0;
            pwm_q.cycle_length_select  <= pwm_wr.cycle_length_select;
         end
         else if (cyc_wrap)
            pwm_q.cycle_ovf_flag <= 1'b1;
      end
   end

   // Counter overflow flag; software may write it, hardware only sets it.
   always_ff @(posedge sys_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         cnt_ovf_flag_q <= 1'b0;
      else if (ce_in)
      begin
         if (wr_lane0 && idx == STATUS_IDX)
            cnt_ovf_flag_q <= wb_dat_in[STATUS_OVF_BIT] || cnt_wrap;
         else if (cnt_wrap)
            cnt_ovf_flag_q <= 1'b1;
      end
   end

   // Per-channel compare and reload words behind the shared address window.
   generate
      for (genvar ch = 0; ch < NUM_CH; ch++)
      begin : g_chan
         logic sel_here;
         logic wr_low;
         logic wr_high;
         logic len_wide;

         assign sel_here = win_hit && (win_ch == 3'(ch));
         assign wr_low   = wr_lane0 && sel_here && !win_high;
         assign wr_high  = wr_lane0 && sel_here && win_high;
         assign len_wide = pwm_q.cycle_length_select != CL_8;

         always_ff @(posedge sys_clk_in or negedge arst_n_in)
         begin
            if (!arst_n_in)
            begin
               cmp_q[ch] <= 16'h0000;
               rld_q[ch] <= 16'h0000;
            end
            else if (ce_in)
            begin
               if (pwm_q.reload_window_select)
               begin
                  if (wr_low)
                     rld_q[ch][7:0] <= wb_dat_in[7:0];
                  if (wr_high)
                     rld_q[ch][15:8] <= wb_dat_in[7:0];
               end
               else
               begin
                  if (wr_low)
                     cmp_q[ch][7:0] <= wb_dat_in[7:0];
                  if (wr_high)
                     cmp_q[ch][15:8] <= wb_dat_in[7:0];
               end
            end
         end

         // A reload word leaves the block only for an 8-to-11-bit PWM channel with a widened period.
         always_ff @(posedge sys_clk_in or negedge arst_n_in)
         begin
            if (!arst_n_in)
               chan_cfg_out[ch] <= '0;
            else if (ce_in)
            begin
               chan_cfg_out[ch].period_bits <= chan_pwm16_in[ch] ? PERIOD_WIDE
                  : PERIOD_BASE + {3'h0, pwm_q.cycle_length_select};
               chan_cfg_out[ch].reload_active <= chan_pwm_en_in[ch] && !chan_pwm16_in[ch]
                                                 && len_wide;
               chan_cfg_out[ch].reload  <= (chan_pwm_en_in[ch] && !chan_pwm16_in[ch] && len_wide)
                                           ? rld_q[ch] : 16'h0000;
               chan_cfg_out[ch].compare <= cmp_q[ch];
            end
         end
      end
   endgenerate

   // Window read picks the bank named by the select bit; an index past the last channel reads zero.
   always_comb
   begin
      win_word = 16'h0000;
      for (int i = 0; i < NUM_CH; i++)
      begin
         if (win_ch == 3'(i))
            win_word = pwm_q.reload_window_select ? rld_q[i] : cmp_q[i];
      end
   end

   // Read data; unmapped addresses answer with zero and ignore writes.
   always_comb
   begin
      rd_d   = 32'h0000_0000;
      mapped = 1'b1;
      if (idx == MODE_IDX)
         rd_d[7:0] = {mode_q.idle_suspend, mode_q.wdog_enable, mode_q.wdog_enable_lock,
                      1'b0, mode_q.timebase_select, mode_q.counter_ovf_irq_enable};
      else if (idx == PWM_IDX)
         rd_d[7:0] = {pwm_q.reload_window_select, pwm_q.cycle_ovf_irq_enable,
                      pwm_q.cycle_ovf_flag, 3'h0, pwm_q.cycle_length_select};
      else if (idx == STATUS_IDX)
         rd_d[STATUS_OVF_BIT] = cnt_ovf_flag_q;
      else if (idx == COUNT_IDX)
         rd_d[15:0] = cnt_q;
      else if (win_hit)
         rd_d[7:0] = win_high ? win_word[15:HIGH_BYTE_LSB] : win_word[7:0];
      else
         mapped = 1'b0;
   end

   // Bus answer: one wait state, ack for one cycle, data held from the ack until the next read request.
   always_ff @(posedge sys_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end
      else if (ce_in)
      begin
         ack_q <= req;
         if (req && !wb_we_in)
            dat_q <= mapped ? rd_d : 32'h0000_0000;
      end
   end

   assign wb_ack_out = ack_q;
   assign wb_dat_out = dat_q;

   // Registered status outputs.
   always_ff @(posedge sys_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         irq_out          <= 1'b0;
         wdog_active_out  <= 1'b1;
         main_counter_out <= CNT_RESET;
      end
      else if (ce_in)
      begin
         irq_out          <= (cnt_ovf_flag_q && mode_q.counter_ovf_irq_enable)
                             || (pwm_q.cycle_ovf_flag && pwm_q.cycle_ovf_irq_enable);
         wdog_active_out  <= mode_q.wdog_enable;
         main_counter_out <= cnt_q;
      end
   end

   // The lane-one strobe is accepted but every writable register here is one byte wide.
   logic unused_lane1;
   assign unused_lane1 = wr_lane1;

endmodule // camc_top

// ### testbench/camc_top_bench.sv
// Self-checking bench for the counter array mode and PWM configuration block.
`timescale 1ns/10ps
module camc_top_bench;
   import camc_pkg::*;
   typedef struct {logic [15:0] e; logic [15:0] m;} camc_note_s;
   logic sys_clk_in = 1'b0, arst_n_in = 1'b0, ce_in = 1'b1, wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
   logic cpu_idle_in = 1'b0, counter_run_in = 1'b1, timer0_ovf_in = 1'b0, ext_count_input_in = 1'b0;
   logic ext_clk_in = 1'b0, rtc_clk_in = 1'b0, wb_ack_out, wdog_active_out, irq_out;
   logic [11:0]                 wb_adr_in = 12'h000;
   logic [3:0]                  wb_sel_in = 4'h1;
   logic [31:0]                 wb_dat_in = 32'h0000_0000, wb_dat_out;
   logic [15:0]                 main_counter_out, c0, d;
   logic [5:0]                  chan_pwm_en_in = 6'h03, chan_pwm16_in = 6'h01;
   camc_chan_cfg_s [NUM_CH-1:0] chan_cfg_out;
   logic [7:0]                  a, b;
   int                          n_mismatch = 0, checks = 0, cycles = 0;
   camc_note_s                  notes[$];
   logic [15:0]                 rate[9] = '{16'd40, 16'd120, 16'd80, 16'd60, 16'd480, 16'd10, 16'd6, 16'd0, 16'd0};
   logic [7:0]                  mset[9] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0a, 8'h0c, 8'h0e, 8'h88};
   camc_top i_camc_top (.*);
   always #4 sys_clk_in = ~sys_clk_in;
   task automatic check(input string what, input logic [15:0] e, g);
      checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // The request is held until ack is sampled; only then is it dropped.
   task automatic bus(input logic we, input logic [9:0] idx, input logic [7:0] dv, input logic [15:0] e, m);
      @(posedge sys_clk_in);
      {wb_cyc_in, wb_stb_in, wb_we_in} <= {2'b11, we};
      wb_adr_in <= {idx, 2'b00};
      wb_dat_in <= {24'h0, dv};
      if (!we)
         notes.push_back('{e, m});
      @(posedge sys_clk_in);
      while (wb_ack_out !== 1'b1)
         @(posedge sys_clk_in);
      d = wb_dat_out[15:0];
      {wb_cyc_in, wb_stb_in} <= 2'b00;
   endtask
   task automatic wr(input logic [9:0] i, input logic [7:0] v);
      bus(1'b1, i, v, 16'h0000, 16'h0000);
   endtask
   task automatic rd(input logic [9:0] i, input logic [7:0] v);
      bus(1'b0, i, 8'h00, {8'h00, v}, 16'h00ff);
   endtask
   always @(posedge sys_clk_in)
      if (wb_ack_out === 1'b1 && wb_cyc_in && !wb_we_in && notes.size() > 0)
      begin
         if (notes[0].m != 16'h0000)
            check("read data", notes[0].e, wb_dat_out[15:0] & notes[0].m);
         void'(notes.pop_front());
      end
   // Pin sources run at fixed periods so each timebase has a known count rate.
   always @(posedge sys_clk_in)
   begin
      cycles <= cycles + 1;
      timer0_ovf_in <= (cycles % 6 == 0);
      if (cycles % 4 == 0)
         ext_count_input_in <= ~ext_count_input_in;
      if (cycles % 3 == 0)
         ext_clk_in <= ~ext_clk_in;
      if (cycles % 5 == 0)
         rtc_clk_in <= ~rtc_clk_in;
      if (cycles > 90000)
      begin
         n_mismatch++;
         final_report();
      end
   end
   initial
   begin
      void'($urandom(59136));
      repeat (20) @(posedge sys_clk_in);
      arst_n_in <= 1'b1;
      rd(MODE_IDX, 8'h40);
      rd(PWM_IDX, 8'h00);
      rd(10'h000, 8'h00);
      check("wdog", 16'h1, 16'(wdog_active_out));
      wr(MODE_IDX, 8'haf);
      rd(MODE_IDX, 8'h00);
      check("wdog", 16'h0, 16'(wdog_active_out));
      wr(MODE_IDX, 8'h9f);
      rd(MODE_IDX, 8'h8f);
      $display("test mode access done");
      cpu_idle_in <= 1'b1;
      for (int i = 0; i < 9; i++)
      begin
         wr(MODE_IDX, mset[i]);
         bus(1'b0, COUNT_IDX, 8'h00, 16'h0000, 16'h0000);
         c0 = d;
         repeat (477) @(posedge sys_clk_in);
         bus(1'b0, COUNT_IDX, 8'h00, 16'h0000, 16'h0000);
         d = d - c0;
         check("rate", rate[i], (d + 16'h0002 >= rate[i] && d <= rate[i] + 16'h0002) ? rate[i] : d);
      end
      cpu_idle_in <= 1'b0;
      $display("test timebase done");
      for (int i = 0; i < 4; i++)
      begin
         wr(PWM_IDX, 8'(i));
         repeat (2) @(posedge sys_clk_in);
         check("period", 16'(8 + i), 16'(chan_cfg_out[1].period_bits));
         check("wide", 16'h0010, 16'(chan_cfg_out[0].period_bits));
         check("reload on", 16'(i != 0), 16'(chan_cfg_out[1].reload_active));
      end
      a = 8'($urandom);
      b = 8'($urandom);
      wr(WIN_BASE_IDX + 10'h002, a);
      wr(PWM_IDX, 8'h83);
      wr(WIN_BASE_IDX + 10'h002, b);
      rd(WIN_BASE_IDX + 10'h002, b);
      wr(PWM_IDX, 8'h03);
      rd(WIN_BASE_IDX + 10'h002, a);
      check("compare", {8'h00, a}, {8'h00, chan_cfg_out[1].compare[7:0]});
      check("reload", {8'h00, b}, {8'h00, chan_cfg_out[1].reload[7:0]});
      chan_pwm_en_in <= 6'h01;
      repeat (2) @(posedge sys_clk_in);
      check("reload off", 16'h0000, 16'(chan_cfg_out[1].reload_active));
      chan_pwm_en_in <= 6'h03;
      $display("test channel config done");
      wr(MODE_IDX, 8'h09);
      repeat (2100) @(posedge sys_clk_in);
      rd(PWM_IDX, 8'h23);
      check("irq", 16'h0, 16'(irq_out));
      wr(PWM_IDX, 8'h7f);
      repeat (2) @(posedge sys_clk_in);
      check("irq", 16'h1, 16'(irq_out));
      rd(PWM_IDX, 8'h63);
      wr(PWM_IDX, 8'h03);
      repeat (2) @(posedge sys_clk_in);
      while (irq_out !== 1'b1)
         @(posedge sys_clk_in);
      rd(STATUS_IDX, 8'h80);
      wr(MODE_IDX, 8'h08);
      repeat (2) @(posedge sys_clk_in);
      check("irq", 16'h0, 16'(irq_out));
      wr(STATUS_IDX, 8'h00);
      rd(STATUS_IDX, 8'h00);
      ce_in <= 1'b0;
      repeat (2) @(posedge sys_clk_in);
      c0 = main_counter_out;
      repeat (8) @(posedge sys_clk_in);
      check("frozen counter", c0, main_counter_out);
      ce_in <= 1'b1;
      $display("test overflow flags done");
      wr(MODE_IDX, 8'h20);
      rd(MODE_IDX, 8'h60);
      wr(MODE_IDX, 8'h00);
      rd(MODE_IDX, 8'h60);
      arst_n_in <= 1'b0;
      repeat (3) @(posedge sys_clk_in);
      arst_n_in <= 1'b1;
      rd(MODE_IDX, 8'h40);
      repeat (2) @(posedge sys_clk_in);
      $display("test lock done");
      final_report();
   end
endmodule // camc_top_bench

// ### testbench/camc_top_monitor.sv
// Checker for bus timing, read-zero bits, reset state and channel outputs of the counter array block.
`timescale 1ns/10ps
module camc_top_monitor (
   input wire logic                                            sys_clk_in,
   input wire logic                                            arst_n_in,
   input wire logic                                            ce_in,
   input wire logic                                            wb_cyc_in,
   input wire logic                                            wb_stb_in,
   input wire logic                                            wb_we_in,
   input wire logic [11:0]                                     wb_adr_in,
   input wire logic [31:0]                                     wb_dat_out,
   input wire logic                                            wb_ack_out,
   input wire logic [15:0]                                     main_counter_out,
   input wire logic                                            wdog_active_out,
   input wire logic [camc_pkg::NUM_CH-1:0]                     chan_pwm_en_in,
   input wire logic [camc_pkg::NUM_CH-1:0]                     chan_pwm16_in,
   input wire camc_pkg::camc_chan_cfg_s [camc_pkg::NUM_CH-1:0] chan_cfg_out
);
   import camc_pkg::*;
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!arst_n_in);
   sequence s_take;
      ce_in && wb_cyc_in && wb_stb_in && !wb_ack_out;
   endsequence
   sequence s_read(logic [9:0] idx);
      s_take ##0 (!wb_we_in && wb_adr_in[11:2] == idx);
   endsequence
   AST_ACK_AFTER_TAKE: assert property (s_take |=> wb_ack_out)
      else $error("ack missing after request");
   AST_ACK_ONE_CYCLE: assert property (wb_ack_out && ce_in |=> !wb_ack_out)
      else $error("ack longer than one cycle");
   AST_MODE_BIT4_LOW: assert property (s_read(MODE_IDX) |=> wb_ack_out && !wb_dat_out[4])
      else $error("mode bit four read high");
   AST_PWM_GAP_LOW: assert property (s_read(PWM_IDX) |=> wb_dat_out[4:2] == 3'h0)
      else $error("pwm bits four to two read high");
   AST_WDOG_AT_RESET: assert property ($rose(arst_n_in) |-> wdog_active_out)
      else $error("watchdog off after reset");
   AST_PERIOD_WIDE: assert property (ce_in && chan_pwm_en_in[0] && chan_pwm16_in[0]
      |=> chan_cfg_out[0].period_bits == PERIOD_WIDE) else $error("wide channel period wrong");
   AST_RELOAD_IDLE: assert property (ce_in && !chan_pwm_en_in[1]
      |=> !chan_cfg_out[1].reload_active && chan_cfg_out[1].reload == 16'h0000) else $error("reload on idle channel");
   AST_COUNT_STEP: assert property ($changed(main_counter_out)
      |-> main_counter_out == $past(main_counter_out) + 16'h0001) else $error("counter step not one");
endmodule // camc_top_monitor

bind camc_top camc_top_monitor i_camc_top_monitor (.*);
